// ### src/pattern_test_unit.sv
// pattern test unit: feeds patterned data to the engine on a file write, checks it on a file read
// assumes: one clock; rd_fifo_no_data is a look-ahead empty (high while one word or less remains),
// rd_fifo_data is show-ahead and belongs to the cycle in which rd_fifo_pop is high
`timescale 1ns/1ps
`include "ptu_defines.svh"

module pattern_test_unit
	import ptu_pkg::*;
#(
	parameter int FIFO_DEPTH = `PTU_FIFO_DEPTH,
	parameter int FIFO_AF_MARGIN = `PTU_FIFO_AF_MARGIN,
	// code 0 size can be lowered so that a whole write fits a short self-test
	parameter logic [31:0] FSIZE_BLK_CODE0 = `PTU_FSIZE_BLK_C0
)
(
	input wire logic core_clk,
	input wire logic srst,
	input wire logic [2:0] file_size_code,
	input wire logic [26:0] first_file_index,
	input wire logic [26:0] file_count,
	input wire logic cmd_write_req,
	input wire logic cmd_read_req,
	input wire logic verify_enable,
	input wire logic [2:0] pattern_sel,
	output logic to_engine_valid,
	output logic [`PTU_DATA_W-1:0] to_engine_data,
	input wire logic to_engine_ready,
	input wire logic rd_fifo_no_data,
	input wire logic [`PTU_DATA_W-1:0] rd_fifo_data,
	output logic rd_fifo_pop,
	output logic write_pattern_start_pulse,
	output logic write_transaction_active,
	output logic read_active,
	output logic write_done,
	output logic verify_fail,
	output logic [63:0] data_count
);
	ptu_top_st_t st_ff;
	ptu_top_st_t nxt_st;
	logic [31:0] fsize_blk;
	logic [63:0] start_addr;
	logic [63:0] end_calc;
	logic accept;
	logic pat_load;
	logic pat_adv;
	logic [`PTU_DATA_W-1:0] pat_word;
	logic fifo_room;
	logic wr_fifo_almost_full;
	logic wr_fifo_push;
	logic last_push;
	logic mismatch;

	// integrator-fixed size lookup, one entry per code
	function automatic logic [31:0] ptu_fsize_blocks(input logic [2:0] code);
		logic [31:0] blk;
		case (code)
			3'h0: blk = FSIZE_BLK_CODE0;
			3'h1: blk = `PTU_FSIZE_BLK_C1;
			3'h2: blk = `PTU_FSIZE_BLK_C2;
			3'h3: blk = `PTU_FSIZE_BLK_C3;
			3'h4: blk = `PTU_FSIZE_BLK_C4;
			3'h5: blk = `PTU_FSIZE_BLK_C5;
			3'h6: blk = `PTU_FSIZE_BLK_C6;
			3'h7: blk = `PTU_FSIZE_BLK_C7;
			default: blk = FSIZE_BLK_CODE0;
		endcase
		return blk;
	endfunction

	always_comb
	begin
		fsize_blk = ptu_fsize_blocks(file_size_code);
		start_addr = 64'(first_file_index) * 64'(fsize_blk);
		// counted in dwords: blocks times dwords per block; sizes past 2^64 dwords wrap
		end_calc = (64'(file_count) * 64'(fsize_blk)) << `PTU_DWORD_SHIFT;
	end

	assign wr_fifo_almost_full = !fifo_room;
	assign wr_fifo_push = st_ff.push;
	assign last_push = st_ff.push && (st_ff.total + 64'h1 == st_ff.end_size);
	assign mismatch = st_ff.pop && st_ff.verify && (rd_fifo_data != pat_word);
	// a write runs to its end; new commands are only taken while idle or reading
	assign accept = (st_ff.mode != PTU_WRITE) && (cmd_write_req || cmd_read_req);
	assign pat_load = accept;

	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.start = 1'b0;
		pat_adv = 1'b0;
		case (st_ff.mode)
			PTU_IDLE, PTU_READ:
			begin
				nxt_st.pop = 1'b0;
				if (accept)
				begin
					// settings are captured here and held for the whole transfer
					nxt_st.pat = ptu_pat_t'(pattern_sel);
					nxt_st.verify = verify_enable;
					nxt_st.end_size = end_calc;
					nxt_st.total = '0;
					nxt_st.done = 1'b0;
					if (cmd_write_req)
					begin
						nxt_st.mode = PTU_WRITE;
						nxt_st.start = 1'b1;
					end
					else
					begin
						nxt_st.mode = PTU_READ;
					end
				end
				else if (st_ff.mode == PTU_READ)
				begin
					nxt_st.pop = !rd_fifo_no_data;
					if (st_ff.pop)
					begin
						nxt_st.total = st_ff.total + 64'h1;
						pat_adv = 1'b1;
					end
				end
			end
			PTU_WRITE:
			begin
				if (st_ff.start)
				begin
					if (st_ff.end_size == '0)
					begin
						nxt_st.mode = PTU_IDLE;
						nxt_st.done = 1'b1;
					end
					else
						nxt_st.trans = 1'b1;
				end
				if (st_ff.push)
					nxt_st.total = st_ff.total + 64'h1;
				if (last_push)
				begin
					nxt_st.trans = 1'b0;
					nxt_st.push = 1'b0;
					nxt_st.mode = PTU_IDLE;
					nxt_st.done = 1'b1;
				end
				else
					nxt_st.push = st_ff.trans && !wr_fifo_almost_full;
				if (nxt_st.push)
				begin
					nxt_st.wdata = pat_word;
					pat_adv = 1'b1;
				end
			end
			default:
			begin
				nxt_st.mode = PTU_IDLE;
				nxt_st.trans = 1'b0;
				nxt_st.push = 1'b0;
				nxt_st.pop = 1'b0;
			end
		endcase
		// a mismatch in the same cycle as a restart still leaves fail set
		if (accept && cmd_read_req && !cmd_write_req)
			nxt_st.fail = 1'b0;
		if (mismatch)
			nxt_st.fail = 1'b1;
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	ptu_pattern u_pattern
	(
		.clk(core_clk),
		.srst(srst),
		.load(pat_load),
		.load_addr(start_addr),
		.advance(pat_adv),
		.pat(st_ff.pat),
		.word(pat_word)
	);

	// the margin absorbs the one-cycle lag of the registered push
	ptu_fifo #(
		.W(`PTU_DATA_W),
		.DEPTH(FIFO_DEPTH),
		.AF_MARGIN(FIFO_AF_MARGIN)
	) u_to_engine_fifo
	(
		.clk(core_clk),
		.srst(srst),
		.in_valid(wr_fifo_push),
		.in_data(st_ff.wdata),
		.in_ready(fifo_room),
		.out_valid(to_engine_valid),
		.out_data(to_engine_data),
		.out_ready(to_engine_ready)
	);

	assign rd_fifo_pop = st_ff.pop;
	assign write_pattern_start_pulse = st_ff.start;
	assign write_transaction_active = st_ff.trans;
	assign read_active = (st_ff.mode == PTU_READ);
	assign write_done = st_ff.done;
	assign verify_fail = st_ff.fail;
	assign data_count = st_ff.total;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (srst);

	sequence s_start;
		st_ff.start;
	endsequence

	sequence s_trans_up;
		st_ff.trans && !st_ff.start;
	endsequence

	property p_start_then_trans;
		s_start ##0 (st_ff.end_size != '0) |=> s_trans_up;
	endproperty
	a_start_then_trans: assert property (p_start_then_trans) else $error("start pulse not followed by transaction");

	property p_push_gate;
		st_ff.push |-> $past(st_ff.trans) && !$past(wr_fifo_almost_full);
	endproperty
	a_push_gate: assert property (p_push_gate) else $error("push without transaction or room");

	property p_pause;
		st_ff.mode == PTU_WRITE && wr_fifo_almost_full |=> !st_ff.push;
	endproperty
	a_pause: assert property (p_pause) else $error("push continued while almost full");

	property p_push_count;
		st_ff.push |=> st_ff.total == $past(st_ff.total) + 64'h1;
	endproperty
	a_push_count: assert property (p_push_count) else $error("total did not follow push");

	sequence s_last;
		last_push;
	endsequence

	property p_end_stop;
		s_last |=> !st_ff.trans && !st_ff.push ##1 !st_ff.push;
	endproperty
	a_end_stop: assert property (p_end_stop) else $error("write did not stop at end size");

	property p_pop_gate;
		st_ff.pop |-> $past(!rd_fifo_no_data) && $past(st_ff.mode == PTU_READ);
	endproperty
	a_pop_gate: assert property (p_pop_gate) else $error("pop without data");

	property p_pop_count;
		st_ff.pop && !accept |=> st_ff.total == $past(st_ff.total) + 64'h1;
	endproperty
	a_pop_count: assert property (p_pop_count) else $error("pop did not advance data count");

	property p_fail_set;
		mismatch |=> st_ff.fail [*2];
	endproperty
	a_fail_set: assert property (p_fail_set) else $error("mismatch did not raise fail");

	property p_end_load;
		s_start |-> st_ff.end_size == $past(end_calc);
	endproperty
	a_end_load: assert property (p_end_load) else $error("end size not captured at start");

endmodule

// ### src/ptu_defines.svh
// constants of the pattern test unit: data widths, block layout, file-size lookup, fifo sizing
// assumes: included by bare name from the package and the pattern_test_unit and ptu_pattern modules
`ifndef PTU_DEFINES_SVH
`define PTU_DEFINES_SVH

`define PTU_DATA_W 32
`define PTU_IDX_W 7
`define PTU_HDR_LAST_IDX 7'h01
`define PTU_BLK_LAST_IDX 7'h7F
`define PTU_DWORD_SHIFT 7
`define PTU_INC_W 55
`define PTU_LFSR_W 32
`define PTU_LFSR_TAP_HI 30
`define PTU_LFSR_TAP_MID 20
`define PTU_LFSR_TAP_LO 0
`define PTU_FIFO_DEPTH 32
`define PTU_FIFO_AF_MARGIN 4

// file-size code to blocks of 512 bytes per file
`define PTU_FSIZE_BLK_C0 32'h0000_0800
`define PTU_FSIZE_BLK_C1 32'h0000_2000
`define PTU_FSIZE_BLK_C2 32'h0000_8000
`define PTU_FSIZE_BLK_C3 32'h0002_0000
`define PTU_FSIZE_BLK_C4 32'h0008_0000
`define PTU_FSIZE_BLK_C5 32'h0020_0000
`define PTU_FSIZE_BLK_C6 32'h0080_0000
`define PTU_FSIZE_BLK_C7 32'h0200_0000

`endif

// ### src/ptu_pkg.sv
// types shared by the pattern test unit modules
// assumes: ptu_defines.svh is on the include path
`include "ptu_defines.svh"

package ptu_pkg;

	typedef enum logic [2:0] {PTU_PAT_ZERO, PTU_PAT_ONE, PTU_PAT_INC, PTU_PAT_DEC, PTU_PAT_LFSR} ptu_pat_t;

	typedef enum logic [1:0] {PTU_IDLE, PTU_WRITE, PTU_READ} ptu_mode_t;

	typedef struct packed {
		logic [`PTU_IDX_W-1:0] idx;
		logic [63:0] addr;
		logic [`PTU_INC_W-1:0] inc;
		logic [`PTU_LFSR_W-1:0] lfsr;
	} ptu_pat_st_t;

	typedef struct packed {
		ptu_mode_t mode;
		ptu_pat_t pat;
		logic verify;
		logic start;
		logic trans;
		logic push;
		logic [`PTU_DATA_W-1:0] wdata;
		logic pop;
		logic fail;
		logic done;
		logic [63:0] total;
		logic [63:0] end_size;
	} ptu_top_st_t;

endpackage

// ### src/ptu_fifo.sv
// fifo between the generator and the engine, with a registered output stage
// assumes: DEPTH is a power of two; in_ready drops AF_MARGIN words early so a late push still fits
`timescale 1ns/1ps

module ptu_fifo
	import ptu_pkg::*;
#(
	parameter int W = 32,
	parameter int DEPTH = 32,
	parameter int AF_MARGIN = 4
)
(
	input wire logic clk,
	input wire logic srst,
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_LVL = (AW+1)'(DEPTH);
	localparam logic [AW:0] AF_LVL = (AW+1)'(DEPTH - AF_MARGIN);

	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
		logic ovalid;
		logic [W-1:0] odata;
	} ptu_fifo_st_t;

	ptu_fifo_st_t s_ff;
	ptu_fifo_st_t nxt_s;
	logic [W-1:0] mem [DEPTH];
	logic wr;
	logic rd;

	always_comb
	begin
		nxt_s = s_ff;
		wr = in_valid && (s_ff.cnt < FULL_LVL);
		rd = (s_ff.cnt != '0) && (!s_ff.ovalid || out_ready);
		if (wr)
			nxt_s.wp = s_ff.wp + 1'b1;
		if (rd)
		begin
			nxt_s.rp = s_ff.rp + 1'b1;
			nxt_s.ovalid = 1'b1;
			nxt_s.odata = mem[s_ff.rp];
		end
		else if (out_ready)
			nxt_s.ovalid = 1'b0;
		case ({wr, rd})
			2'b10: nxt_s.cnt = s_ff.cnt + 1'b1;
			2'b01: nxt_s.cnt = s_ff.cnt - 1'b1;
			default: nxt_s.cnt = s_ff.cnt;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end

	// storage carries no reset, only the pointers, the count and the output stage do
	always_ff @(posedge clk)
	begin
		if (wr)
			mem[s_ff.wp] <= in_data;
	end

	assign in_ready = s_ff.cnt < AF_LVL;
	assign out_valid = s_ff.ovalid;
	assign out_data = s_ff.odata;

endmodule

// ### src/ptu_pattern.sv
// regenerates the block-structured test stream: 64-bit address header, then pattern dwords
// assumes: load and advance come from the owning control logic; word is valid every cycle
`timescale 1ns/1ps
`include "ptu_defines.svh"

module ptu_pattern
	import ptu_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic load,
	input wire logic [63:0] load_addr,
	input wire logic advance,
	input wire ptu_pat_t pat,
	output logic [`PTU_DATA_W-1:0] word
);
	ptu_pat_st_t s_ff;
	ptu_pat_st_t nxt_s;
	logic fb;
	logic [63:0] next_addr;

	always_comb
	begin
		nxt_s = s_ff;
		fb = s_ff.lfsr[`PTU_LFSR_TAP_HI] ^ s_ff.lfsr[`PTU_LFSR_TAP_MID] ^ s_ff.lfsr[`PTU_LFSR_TAP_LO];
		next_addr = s_ff.addr + 64'h1;
		if (load)
		begin
			nxt_s.idx = '0;
			nxt_s.addr = load_addr;
			nxt_s.inc = load_addr[`PTU_INC_W-1:0];
			nxt_s.lfsr = load_addr[`PTU_LFSR_W-1:0];
		end
		else if (advance)
		begin
			nxt_s.idx = s_ff.idx + 1'b1;
			if (s_ff.idx == `PTU_BLK_LAST_IDX)
			begin
				// each new block reseeds from its own address so its content depends on that address alone
				nxt_s.addr = next_addr;
				nxt_s.inc = next_addr[`PTU_INC_W-1:0];
				nxt_s.lfsr = next_addr[`PTU_LFSR_W-1:0];
			end
			else if (s_ff.idx > `PTU_HDR_LAST_IDX)
			begin
				nxt_s.inc = s_ff.inc + 1'b1;
				nxt_s.lfsr = {s_ff.lfsr[`PTU_LFSR_W-2:0], fb};
			end
		end
	end

	always_comb
	begin
		if (s_ff.idx == '0)
			word = s_ff.addr[31:0];
		else if (s_ff.idx == `PTU_HDR_LAST_IDX)
			word = s_ff.addr[63:32];
		else
		begin
			case (pat)
				PTU_PAT_ZERO: word = 32'h0000_0000;
				PTU_PAT_ONE: word = 32'hFFFF_FFFF;
				PTU_PAT_INC: word = s_ff.inc[31:0];
				PTU_PAT_DEC: word = ~s_ff.inc[31:0];
				PTU_PAT_LFSR: word = s_ff.lfsr;
				default: word = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	property p_addr_step;
		advance && !load && s_ff.idx == `PTU_BLK_LAST_IDX |=> s_ff.addr == $past(s_ff.addr) + 64'h1 && s_ff.idx == '0;
	endproperty
	a_addr_step: assert property (p_addr_step) else $error("block address did not step after last dword");

	property p_header;
		advance && !load && s_ff.idx == '0 |=> word == $past(s_ff.addr[63:32]);
	endproperty
	a_header: assert property (p_header) else $error("header upper dword is not the block address");

	property p_dec_inverse;
		pat == PTU_PAT_DEC && advance && !load && s_ff.idx > `PTU_HDR_LAST_IDX && s_ff.idx != `PTU_BLK_LAST_IDX
			|=> word == $past(word) - 32'h1;
	endproperty
	a_dec_inverse: assert property (p_dec_inverse) else $error("decrement pattern did not count down");

	property p_block_seed;
		advance && !load && s_ff.idx == `PTU_BLK_LAST_IDX |=> s_ff.inc == $past(s_ff.addr[`PTU_INC_W-1:0]) + 55'h1;
	endproperty
	a_block_seed: assert property (p_block_seed) else $error("pattern not reseeded from block address");

endmodule

// ### testbench/ptu_engine_model.sv
// far side model: engine taking generator words, and the read fifo feeding the checker
// assumes: the bench sets stall and loads read words with put()
`timescale 1ns/1ps

module ptu_engine_model
	import ptu_pkg::*;
(
	input wire logic core_clk,
	input wire logic srst,
	input wire logic stall,
	output logic to_engine_ready,
	input wire logic rd_fifo_pop,
	output logic rd_fifo_no_data,
	output logic [31:0] rd_fifo_data
);
	logic [31:0] q[$];
	logic [31:0] last = 32'h0;
	int seed = 5721;

	task automatic upd;
		// look-ahead empty, so the checker never pops a word that is not there
		rd_fifo_no_data = q.size() <= 1;
		// a drained fifo shows the inverse of the last word, never a stale copy
		rd_fifo_data = (q.size() > 0) ? q[0] : ~last;
	endtask

	task automatic put(input logic [31:0] w);
		q.push_back(w);
		upd;
	endtask

	initial
	begin
		to_engine_ready = 1'b0;
		upd;
	end

	always @(posedge core_clk)
	begin
		if (srst)
			q = {};
		else if (rd_fifo_pop && q.size() > 0)
			last = q.pop_front();
		#1;
		// the engine pauses at random, as a disk transfer would
		to_engine_ready = !srst && !stall && ({$random(seed)} % 4 != 0);
		upd;
	end
endmodule

// ### testbench/pattern_test_unit_tb.sv
// bench for the pattern test unit: write stream with back-pressure, read check
// assumes: ptu_engine_model stands in for the engine and its read fifo
`timescale 1ns/1ps
`include "ptu_defines.svh"

module pattern_test_unit_tb;
	import ptu_pkg::*;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic [2:0] file_size_code = 3'h0;
	logic [26:0] first_file_index = 27'h0;
	logic [26:0] file_count = 27'h0;
	logic cmd_write_req = 1'b0;
	logic cmd_read_req = 1'b0;
	logic verify_enable = 1'b0;
	logic [2:0] pattern_sel = 3'h0;
	logic stall = 1'b1;
	logic [2:0] code_mask = 3'h7;
	logic to_engine_valid, to_engine_ready, rd_fifo_no_data, rd_fifo_pop;
	logic write_pattern_start_pulse, write_transaction_active, read_active, write_done, verify_fail;
	logic [31:0] to_engine_data, rd_fifo_data;
	logic [63:0] data_count, base, snap;
	logic [31:0] exp_q[$];
	// code 0 shrunk to two blocks per file so a write can run to its end
	localparam logic [31:0] SHORT_BLK = 32'h0000_0002;
	logic [31:0] blk_tab[8] = '{SHORT_BLK, `PTU_FSIZE_BLK_C1, `PTU_FSIZE_BLK_C2, `PTU_FSIZE_BLK_C3,
		`PTU_FSIZE_BLK_C4, `PTU_FSIZE_BLK_C5, `PTU_FSIZE_BLK_C6, `PTU_FSIZE_BLK_C7};
	int num_errors = 0;
	int cmp_count = 0;
	int seed = 5721;
	int i;

	always #2.5 core_clk = ~core_clk;

	pattern_test_unit #(
		.FSIZE_BLK_CODE0(SHORT_BLK)
	) uut
	(
		.core_clk, .srst, .file_size_code, .first_file_index, .file_count, .cmd_write_req,
		.cmd_read_req, .verify_enable, .pattern_sel, .to_engine_valid, .to_engine_data,
		.to_engine_ready, .rd_fifo_no_data, .rd_fifo_data, .rd_fifo_pop, .write_pattern_start_pulse,
		.write_transaction_active, .read_active, .write_done, .verify_fail, .data_count
	);

	ptu_engine_model eng
	(
		.core_clk, .srst, .stall, .to_engine_ready, .rd_fifo_pop, .rd_fifo_no_data, .rd_fifo_data
	);

	task automatic end_sim;
		if (num_errors == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input logic [63:0] got, input logic [63:0] want);
		cmp_count++;
		if (got !== want)
		begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, want);
		end
	endtask

	task automatic chk_w(input logic [31:0] got, input logic [31:0] want);
		chk({32'h0, got}, {32'h0, want});
	endtask

	// stream word k: header dwords, then pattern seeded by the block address
	function automatic logic [31:0] exp_word(input int p, input int k);
		logic [63:0] a;
		logic [31:0] l;
		a = base + k / 128;
		l = a[31:0];
		if (k % 128 < 2)
			return (k % 128 == 0) ? a[31:0] : a[63:32];
		if (p == 4)
			repeat (k % 128 - 2)
				l = {l[30:0], l[30] ^ l[20] ^ l[0]};
		case (p)
			1: return 32'hFFFF_FFFF;
			2: return l + k % 128 - 2;
			3: return ~(l + k % 128 - 2);
			4: return l;
			default: return 32'h0;
		endcase
	endfunction

	always @(posedge core_clk)
		if (!srst && to_engine_valid && to_engine_ready && exp_q.size() > 0)
			chk_w(to_engine_data, exp_q.pop_front());

	task automatic cmd(input logic wr, input int p, input logic [26:0] cnt, input logic ver);
		@(posedge core_clk);
		#1;
		file_size_code = 3'($random(seed)) & code_mask;
		first_file_index = 27'($random(seed));
		file_count = cnt;
		pattern_sel = 3'(p);
		verify_enable = ver;
		cmd_write_req = wr;
		cmd_read_req = !wr;
		base = 64'(first_file_index) * 64'(blk_tab[file_size_code]);
		@(posedge core_clk);
		#1;
		cmd_write_req = 1'b0;
		cmd_read_req = 1'b0;
	endtask

	task automatic wait_q(input int m);
		for (int t = 0; t < 4000 && exp_q.size() > m; t++)
			@(posedge core_clk);
		#1;
		chk(exp_q.size() > m, 0);
	endtask

	task automatic rst_chk;
		srst = 1'b1;
		repeat (2) @(posedge core_clk);
		#1;
		srst = 1'b0;
		chk({57'h0, to_engine_valid, rd_fifo_pop, write_pattern_start_pulse, write_transaction_active,
			read_active, write_done, verify_fail}, 0);
		chk(data_count, 0);
	endtask

	task automatic wr_run(input int p);
		exp_q = {};
		stall = 1'b0;
		cmd(1'b1, p, 27'h3, 1'b0);
		for (i = 0; i < 300; i++)
			exp_q.push_back(exp_word(p, i));
		chk({write_pattern_start_pulse, write_transaction_active}, 2'b10);
		@(posedge core_clk);
		#1;
		chk({write_pattern_start_pulse, write_transaction_active}, 2'b01);
		wait_q(150);
		// engine stalls long enough for the fifo to refuse more words
		stall = 1'b1;
		repeat (60) @(posedge core_clk);
		#1;
		snap = data_count;
		repeat (8) @(posedge core_clk);
		#1;
		chk(data_count, snap);
		chk(to_engine_valid, 1);
		stall = 1'b0;
		wait_q(0);
		chk(write_transaction_active, 1);
		rst_chk;
	endtask

	task automatic rd_run(input int p, input logic ver, input logic bad);
		cmd(1'b0, p, 27'h1, ver);
		chk(read_active, 1);
		for (i = 0; i < 200; i++)
			eng.put(exp_word(p, i) ^ ((bad && i == 130) ? 32'h10 : 32'h0));
		for (i = 0; i < 2000 && eng.q.size() > 1; i++)
			@(posedge core_clk);
		repeat (4) @(posedge core_clk);
		#1;
		chk(data_count, 200 - eng.q.size());
		chk(verify_fail, ver & bad);
		chk(eng.q.size() <= 1, 1);
		// a fresh read clears the sticky fail
		cmd(1'b0, p, 27'h1, ver);
		@(posedge core_clk);
		#1;
		chk(verify_fail, 0);
		rst_chk;
	endtask

	initial
	begin
		#500000;
		num_errors++;
		end_sim;
	end

	initial
	begin
		repeat (8) @(posedge core_clk);
		#1;
		rst_chk;
		for (int p = 0; p < 6; p++)
			wr_run(p);
		cmd(1'b1, 2, 27'h0, 1'b0);
		@(posedge core_clk);
		#1;
		chk({write_done, write_transaction_active}, 2'b10);
		repeat (10) @(posedge core_clk);
		#1;
		chk(to_engine_valid, 0);
		chk(data_count, 0);
		rst_chk;
		// short file of two blocks: the write ends by itself, a read during it is ignored
		code_mask = 3'h0;
		exp_q = {};
		stall = 1'b0;
		cmd(1'b1, 2, 27'h1, 1'b0);
		for (i = 0; i < 256; i++)
			exp_q.push_back(exp_word(2, i));
		cmd_read_req = 1'b1;
		@(posedge core_clk);
		#1;
		cmd_read_req = 1'b0;
		chk({read_active, write_transaction_active}, 2'b01);
		wait_q(0);
		repeat (8) @(posedge core_clk);
		#1;
		chk(data_count, 256);
		chk({write_done, write_transaction_active, to_engine_valid}, 3'b100);
		code_mask = 3'h7;
		rst_chk;
		rd_run(2, 1'b1, 1'b1);
		rd_run(4, 1'b1, 1'b0);
		rd_run(3, 1'b0, 1'b1);
		rd_run(1, 1'b1, 1'b1);
		end_sim;
	end
endmodule
